// file: esic_pkg.sv
package esic_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFF_IE     = 8'h00;
  localparam logic [7:0] OFF_IPL    = 8'h04;
  localparam logic [7:0] OFF_IPH    = 8'h08;
  localparam logic [7:0] OFF_EXT23_CONTROL_REG  = 8'h0C;
  localparam logic [7:0] OFF_TCTL   = 8'h10;
  localparam logic [7:0] OFF_FLAGS  = 8'h14;
  localparam logic [7:0] OFF_PCTL   = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // Enable register fields
  localparam int IE_GLOBAL = 7;
  localparam int IE_RSVD   = 6;

  // Ext 2/3 control register fields
  localparam int XC_PRIO3 = 7;
  localparam int XC_EN3   = 6;
  localparam int XC_FLAG3 = 5;
  localparam int XC_TRIG3 = 4;
  localparam int XC_PRIO2 = 3;
  localparam int XC_EN2   = 2;
  localparam int XC_FLAG2 = 1;
  localparam int XC_TRIG2 = 0;

  // Timer control register fields
  localparam int TC_TF1  = 7;
  localparam int TC_TF0  = 5;
  localparam int TC_IE1  = 3;
  localparam int TC_IT1  = 2;
  localparam int TC_IE0  = 1;
  localparam int TC_IT0  = 0;

  // Serial / timer 2 flag register fields
  localparam int FL_RX   = 0;
  localparam int FL_TX   = 1;
  localparam int FL_TF2  = 2;
  localparam int FL_TIMER2_EXTERNAL_FLAG = 3;

  // Power control register fields
  localparam int PC_IDLE = 0;
  localparam int PC_PD   = 1;
  localparam int PC_POF  = 4;

  // Source indices in polling order
  localparam int SRC_X0  = 0;
  localparam int SRC_T0  = 1;
  localparam int SRC_X1  = 2;
  localparam int SRC_T1  = 3;
  localparam int SRC_SER = 4;
  localparam int SRC_T2  = 5;
  localparam int SRC_X2  = 6;
  localparam int SRC_X3  = 7;

  localparam logic [7:0] VEC_BASE  = 8'h03;
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLV  = 2'b10;

  // Same-clock one-cycle event pulses from the peripherals
  typedef struct packed {
    logic timer0_ovf;
    logic timer1_ovf;
    logic timer2_ovf;
    logic timer2_ext;
    logic rx_done;
    logic tx_done;
  } esic_events_s;

endpackage

// file: esic_top.sv
// Local design decisions: the register addresses and register access over AXI4-Lite.
module esic_top (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  por_n,
  // AXI4-Lite write address and data
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Interrupt sources
  input  wire logic [3:0]            ext_int_n,
  input  wire esic_pkg::esic_events_s events,
  // CPU core
  output logic                       irq_req,
  output logic [7:0]                 irq_vector,
  input  wire logic                  irq_ack,
  input  wire logic                  irq_return,
  // Power control
  output logic                       cpu_clk_en,
  output logic                       osc_run
);
  import esic_pkg::*;

  logic [7:0]  ie_q;
  logic [5:0]  ipl_q;
  logic [7:0]  iph_q;
  logic [7:0]  ext23_control_reg_q;
  logic [1:0]  trig01_q;
  logic [1:0]  tf01_q;
  logic [3:0]  flags_q;
  logic        idle_q;
  logic        pd_q;
  logic        pof_q;
  logic [3:0]  ext_flag_q;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [3:0]  prev_q;
  logic [3:0]  insvc_q;
  logic        cand_valid_q;
  logic [2:0]  cand_idx_q;
  logic [7:0]  vec_q;

  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  logic        wr_en;
  logic        wr_hit;
  logic [7:0]  wbyte;
  logic [3:0]  trig;
  logic [7:0]  enables;
  logic [7:0]  prio_low;
  logic [7:0]  pend;
  logic [1:0]  lvl [8];
  logic        found;
  logic [2:0]  best_idx;
  logic [1:0]  best_lvl;
  logic        ack_take;
  logic [7:0]  ack_clr;
  logic [7:0]  rd_val;
  logic        rd_hit;

  // ---------------- AXI4-Lite slave ----------------
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign wr_en  = aw_have_q && w_have_q && !bvalid_q;
  assign wbyte  = wdata_q[7:0];
  assign wr_hit = waddr_q[7:5] == 3'b000 && waddr_q[1:0] == 2'b00;

  function automatic logic wsel(input logic [7:0] off);
    return wr_en && waddr_q == off && wstrb_q[0];
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLV;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFF_IE:     rd_val = ie_q;
      OFF_IPL:    rd_val = {2'b00, ipl_q};
      OFF_IPH:    rd_val = iph_q;
      OFF_EXT23_CONTROL_REG:  rd_val = {ext23_control_reg_q[7:6], ext_flag_q[3], ext23_control_reg_q[4:2], ext_flag_q[2],
                            ext23_control_reg_q[0]};
      OFF_TCTL:   rd_val = {tf01_q[1], 1'b0, tf01_q[0], 1'b0, ext_flag_q[1], trig01_q[1],
                            ext_flag_q[0], trig01_q[0]};
      OFF_FLAGS:  rd_val = {4'h0, flags_q};
      OFF_PCTL:   rd_val = {3'b000, pof_q, 2'b00, pd_q, idle_q};
      OFF_STATUS: rd_val = {3'b000, cand_valid_q, insvc_q};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= (s_axi_araddr == OFF_STATUS) ? {16'h0000, vec_q, rd_val} : {24'h00_0000, rd_val};
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLV;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- Configuration registers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie_q     <= RST_REG;
      ipl_q    <= 6'h00;
      iph_q    <= RST_REG;
      ext23_control_reg_q  <= RST_REG;
      trig01_q <= 2'b00;
    end else begin
      if (wsel(OFF_IE)) begin
        ie_q <= wbyte & ~(8'h01 << IE_RSVD);
      end
      if (wsel(OFF_IPL)) begin
        ipl_q <= wbyte[5:0];
      end
      if (wsel(OFF_IPH)) begin
        iph_q <= wbyte;
      end
      if (wsel(OFF_EXT23_CONTROL_REG)) begin
        // Flag bits live in the pending flag logic
        ext23_control_reg_q <= wbyte & ~((8'h01 << XC_FLAG3) | (8'h01 << XC_FLAG2));
      end
      if (wsel(OFF_TCTL)) begin
        trig01_q <= {wbyte[TC_IT1], wbyte[TC_IT0]};
      end
    end
  end

  assign trig     = {ext23_control_reg_q[XC_TRIG3], ext23_control_reg_q[XC_TRIG2], trig01_q};
  assign enables  = {ext23_control_reg_q[XC_EN3], ext23_control_reg_q[XC_EN2], ie_q[5:0]};
  assign prio_low = {ext23_control_reg_q[XC_PRIO3], ext23_control_reg_q[XC_PRIO2], ipl_q};

  // ---------------- External inputs ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      prev_q  <= 4'hF;
    end else begin
      sync1_q <= ext_int_n;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign ack_take = irq_ack && cand_valid_q;

  always_comb begin
    ack_clr = 8'h00;
    if (ack_take) begin
      ack_clr[cand_idx_q] = 1'b1;
    end
  end

  // Set is applied last so an edge in a clearing cycle survives
  always_ff @(posedge aclk) begin
    logic [3:0] sw_we;
    logic [3:0] sw_val;
    logic [3:0] ack_ext;
    sw_we   = {{2{wsel(OFF_EXT23_CONTROL_REG)}}, {2{wsel(OFF_TCTL)}}};
    sw_val  = {wbyte[XC_FLAG3], wbyte[XC_FLAG2], wbyte[TC_IE1], wbyte[TC_IE0]};
    ack_ext = {ack_clr[SRC_X3], ack_clr[SRC_X2], ack_clr[SRC_X1], ack_clr[SRC_X0]};
    if (!aresetn) begin
      ext_flag_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!trig[i]) begin
          ext_flag_q[i] <= !sync2_q[i];
        end else begin
          if (ack_ext[i]) begin
            ext_flag_q[i] <= 1'b0;
          end
          if (sw_we[i]) begin
            ext_flag_q[i] <= sw_val[i];
          end
          if (prev_q[i] && !sync2_q[i]) begin
            ext_flag_q[i] <= 1'b1;
          end
        end
      end
    end
  end

  // ---------------- Timer and serial flags ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tf01_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ack_clr[i == 0 ? SRC_T0 : SRC_T1]) begin
          tf01_q[i] <= 1'b0;
        end
      end
      if (wsel(OFF_TCTL)) begin
        tf01_q <= {wbyte[TC_TF1], wbyte[TC_TF0]};
      end
      if (events.timer0_ovf) begin
        tf01_q[0] <= 1'b1;
      end
      if (events.timer1_ovf) begin
        tf01_q[1] <= 1'b1;
      end
    end
  end

  // No clear on vectoring: the routine must find out which flag fired
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 4'h0;
    end else begin
      if (wsel(OFF_FLAGS)) begin
        flags_q <= wbyte[3:0];
      end
      if (events.rx_done) begin
        flags_q[FL_RX] <= 1'b1;
      end
      if (events.tx_done) begin
        flags_q[FL_TX] <= 1'b1;
      end
      if (events.timer2_ovf) begin
        flags_q[FL_TF2] <= 1'b1;
      end
      if (events.timer2_ext) begin
        flags_q[FL_TIMER2_EXTERNAL_FLAG] <= 1'b1;
      end
    end
  end

  always_comb begin
    pend          = 8'h00;
    pend[SRC_X0]  = ext_flag_q[0];
    pend[SRC_T0]  = tf01_q[0];
    pend[SRC_X1]  = ext_flag_q[1];
    pend[SRC_T1]  = tf01_q[1];
    pend[SRC_SER] = flags_q[FL_RX] | flags_q[FL_TX];
    pend[SRC_T2]  = flags_q[FL_TF2] | flags_q[FL_TIMER2_EXTERNAL_FLAG];
    pend[SRC_X2]  = ext_flag_q[2];
    pend[SRC_X3]  = ext_flag_q[3];
  end

  // ---------------- Priority resolution ----------------
  always_comb begin
    logic [1:0] top;
    top      = 2'b00;
    found    = 1'b0;
    best_idx = 3'd0;
    best_lvl = 2'b00;
    for (int l = 0; l < 4; l++) begin
      if (insvc_q[l]) begin
        top = 2'(l);
      end
    end
    // Descending scan with >= lets the lower index win a tie
    for (int i = 7; i >= 0; i--) begin
      lvl[i] = {iph_q[i], prio_low[i]};
      if (ie_q[IE_GLOBAL] && enables[i] && pend[i]
          && (insvc_q == 4'h0 || lvl[i] > top)
          && (!found || lvl[i] >= best_lvl)) begin
        found    = 1'b1;
        best_idx = 3'(i);
        best_lvl = lvl[i];
      end
    end
  end

  // Candidate is registered; cycle after an accept is suppressed to avoid a double take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cand_valid_q <= 1'b0;
      cand_idx_q   <= 3'd0;
      vec_q        <= VEC_BASE;
    end else begin
      cand_valid_q <= found && !ack_take;
      cand_idx_q   <= best_idx;
      vec_q        <= VEC_BASE + {2'b00, best_idx, 3'b000};
    end
  end

  assign irq_req    = cand_valid_q;
  assign irq_vector = vec_q;

  always_ff @(posedge aclk) begin
    logic [3:0] nxt;
    nxt = insvc_q;
    if (irq_return) begin
      for (int l = 0; l < 4; l++) begin
        if (insvc_q[l] && (insvc_q >> (l + 1)) == 4'h0) begin
          nxt[l] = 1'b0;
        end
      end
    end
    if (ack_take) begin
      nxt[lvl[cand_idx_q]] = 1'b1;
    end
    if (!aresetn) begin
      insvc_q <= 4'h0;
    end else begin
      insvc_q <= nxt;
    end
  end

  // ---------------- Power control ----------------
  // Reset clears both modes, so a reset wake restarts from zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_q <= 1'b0;
      pd_q   <= 1'b0;
    end else begin
      if (wsel(OFF_PCTL)) begin
        idle_q <= wbyte[PC_IDLE];
        pd_q   <= wbyte[PC_PD];
      end
      if (ie_q[IE_GLOBAL] && |(pend & enables)) begin
        idle_q <= 1'b0;
      end
      if (ie_q[IE_GLOBAL] && |({pend[SRC_X3], pend[SRC_X2], pend[SRC_X1], pend[SRC_X0]}
          & {enables[SRC_X3], enables[SRC_X2], enables[SRC_X1], enables[SRC_X0]})) begin
        pd_q <= 1'b0;
      end
    end
  end

  // Only the power-on reset and a PCTL write touch this flag, never the system reset
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      pof_q <= 1'b1;
    end else if (wsel(OFF_PCTL)) begin
      pof_q <= wbyte[PC_POF];
    end
  end

  assign cpu_clk_en = !idle_q && !pd_q;
  assign osc_run    = !pd_q;

endmodule

// file: esic_cpu_model.sv
module esic_cpu_model (
  // Clock
  input  wire logic       aclk,
  // Controller request
  input  wire logic       irq_req,
  input  wire logic [7:0] irq_vector,
  output logic            irq_ack,
  // Bench control and record
  input  wire logic [3:0] delay,
  output logic [7:0]      taken_vec,
  output int              n_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  initial begin
    irq_ack = 1'b0;
    taken_vec = 8'h00;
    n_taken = 0;
    wait_q = 4'h0;
  end
  // Ack only counts while request high, so vector is latched there
  always @(posedge aclk) begin
    if (irq_ack && irq_req) begin
      irq_ack <= 1'b0;
      taken_vec <= irq_vector;
      n_taken <= n_taken + 1;
      wait_q <= 4'h0;
    end else if (irq_req && !irq_ack && wait_q >= delay) begin
      irq_ack <= 1'b1;
    end else begin
      irq_ack <= 1'b0;
      if (irq_req && !irq_ack) wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// file: esic_top_assertions.sv
module esic_top_assertions (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // Core side
  input wire logic        irq_req,
  input wire logic [7:0]  irq_vector,
  input wire logic        irq_ack,
  input wire logic        cpu_clk_en,
  input wire logic        osc_run
);
  timeunit 1ns;
  timeprecision 1ns;
  import esic_pkg::*;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic wr_both;
  logic wr_bad;
  logic rd_bad;
  assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign wr_bad  = s_axi_awaddr > OFF_STATUS || s_axi_awaddr[1:0] != 2'b00;
  assign rd_bad  = s_axi_araddr > OFF_STATUS || s_axi_araddr[1:0] != 2'b00;
  property p_vec_form;
    irq_req |-> irq_vector[2:0] == 3'b011 && irq_vector[7:6] == 2'b00;
  endproperty
  a_vec_form: assert property (p_vec_form)
    else $error("vector off slot");
  property p_ack_drop;
    irq_ack && irq_req |=> !irq_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("request held after ack");
  property p_wr_resp;
    wr_both |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("no write response");
  property p_wr_bad;
    wr_both && wr_bad |=> ##1 s_axi_bresp == RESP_SLV;
  endproperty
  a_wr_bad: assert property (p_wr_bad)
    else $error("unmapped write not refused");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("no read response");
  property p_rd_bad;
    s_axi_arvalid && s_axi_arready && rd_bad |=>
      s_axi_rresp == RESP_SLV && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read not refused");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write response repeated");
  property p_pd_gate;
    !osc_run |-> !cpu_clk_en;
  endproperty
  a_pd_gate: assert property (p_pd_gate)
    else $error("core clock in power-down");
  // Idle must end once an enabled request reaches the core
  property p_idle_wake;
    osc_run && irq_req |-> ##[0:2] cpu_clk_en;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle not ended");
  c_ack: cover property (irq_ack && irq_req);
  c_idle: cover property (!cpu_clk_en && osc_run);
  c_pd: cover property (!osc_run);
endmodule

bind esic_top esic_top_assertions i_chk (.*);

// file: esic_top_test.sv
module esic_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import esic_pkg::*;
  logic         aclk, aresetn, por_n, irq_req, irq_ack, irq_return;
  logic [7:0]   s_axi_awaddr, s_axi_araddr, irq_vector, taken_vec;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb, ext_int_n, delay;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready, cpu_clk_en, osc_run;
  esic_events_s events;
  int           n_taken, n_exp = 0, n_fail = 0, checked = 0;

  esic_top i_dut (.*);
  esic_cpu_model i_cpu (
    .aclk       (aclk),
    .irq_req    (irq_req),
    .irq_vector (irq_vector),
    .irq_ack    (irq_ack),
    .delay      (delay),
    .taken_vec  (taken_vec),
    .n_taken    (n_taken)
  );

  task automatic chk(input logic [39:0] g, e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
  endtask
  task automatic rd(input logic [7:0] a, e, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata[7:0]}, {1'b1, er, e});
  endtask
  task automatic pulse(input esic_events_s e);
    @(posedge aclk);
    events <= e;
    @(posedge aclk);
    events <= 6'h00;
  endtask
  // Expected count kept here so an early ack is never missed
  task automatic serve(input logic [7:0] e);
    n_exp++;
    repeat (60) if (n_taken < n_exp) @(posedge aclk);
    chk({n_taken == n_exp, taken_vec}, {1'b1, e});
  endtask
  task automatic quiet();
    repeat (12) @(posedge aclk);
    chk(n_taken, n_exp);
  endtask
  task automatic ret();
    @(posedge aclk);
    irq_return <= 1'b1;
    @(posedge aclk);
    irq_return <= 1'b0;
  endtask

  task automatic t_reset();
    rd(OFF_IE, 8'h00);
    rd(OFF_IPL, 8'h00);
    rd(OFF_IPH, 8'h00);
    rd(OFF_EXT23_CONTROL_REG, 8'h00);
    rd(OFF_PCTL, 8'h10);
    rd(8'h20, 8'h00, RESP_SLV);
    wr(8'h22, 8'hFF, RESP_SLV);
  endtask
  task automatic t_gate();
    wr(OFF_IE, 8'h02);
    pulse(6'h20);
    quiet();
    wr(OFF_IE, 8'h80);
    quiet();
    wr(OFF_IE, 8'h82);
    serve(8'h0B);
    rd(OFF_TCTL, 8'h00);
    ret();
  endtask
  task automatic t_order();
    wr(OFF_IE, 8'h00);
    wr(OFF_TCTL, 8'h05);
    wr(OFF_EXT23_CONTROL_REG, 8'h55);
    @(posedge aclk) ext_int_n <= 4'h0;
    pulse(6'h3F);
    repeat (4) @(posedge aclk);
    rd(OFF_EXT23_CONTROL_REG, 8'h77);
    wr(OFF_IE, 8'hBF);
    for (int i = 0; i < 8; i++) begin
      serve(VEC_BASE + 8'(8 * i));
      if (i == SRC_SER) begin
        rd(OFF_FLAGS, 8'h0F);
        wr(OFF_FLAGS, 8'h0C);
      end
      if (i == SRC_T2) begin
        rd(OFF_FLAGS, 8'h0C);
        wr(OFF_FLAGS, 8'h00);
      end
      ret();
    end
    rd(OFF_TCTL, 8'h05);
    rd(OFF_EXT23_CONTROL_REG, 8'h55);
    @(posedge aclk) ext_int_n <= 4'hF;
  endtask
  // Slow core here, so blocking must hold over its reaction time
  task automatic t_prio();
    delay <= 4'h5;
    wr(OFF_IE, 8'h00);
    wr(OFF_IPH, 8'h18);
    wr(OFF_IPL, 8'h0A);
    wr(OFF_FLAGS, 8'h01);
    wr(OFF_TCTL, 8'hA3);
    wr(OFF_IE, 8'h9B);
    serve(8'h1B);
    quiet();
    ret();
    serve(8'h23);
    wr(OFF_FLAGS, 8'h00);
    ret();
    serve(8'h0B);
    ret();
    serve(8'h03);
    wr(OFF_TCTL, 8'h81);
    serve(8'h1B);
    ret();
    ret();
    quiet();
    delay <= 4'h0;
  endtask
  task automatic t_level();
    wr(OFF_TCTL, 8'h00);
    wr(OFF_IE, 8'h84);
    @(posedge aclk) ext_int_n <= 4'hD;
    serve(8'h13);
    rd(OFF_TCTL, 8'h08);
    ret();
    serve(8'h13);
    ext_int_n <= 4'hF;
    repeat (4) @(posedge aclk);
    rd(OFF_TCTL, 8'h00);
    ret();
    quiet();
  endtask
  task automatic t_power();
    wr(OFF_TCTL, 8'h01);
    wr(OFF_IE, 8'h83);
    wr(OFF_PCTL, 8'h01);
    chk({cpu_clk_en, osc_run}, 2'b01);
    pulse(6'h20);
    serve(8'h0B);
    chk(cpu_clk_en, 1'b1);
    rd(OFF_PCTL, 8'h00);
    ret();
    wr(OFF_PCTL, 8'h02);
    chk({cpu_clk_en, osc_run}, 2'b00);
    @(posedge aclk) ext_int_n <= 4'hE;
    serve(8'h03);
    chk(osc_run, 1'b1);
    ret();
    ext_int_n <= 4'hF;
  endtask
  task automatic t_pof();
    wr(OFF_IPH, 8'h5A);
    @(posedge aclk) aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_IPH, 8'h00);
    rd(OFF_IE, 8'h00);
    rd(OFF_PCTL, 8'h00);
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    por_n = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    ext_int_n = 4'hF;
    events = 6'h00;
    irq_return = 1'b0;
    delay = 4'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    t_gate();
    t_order();
    t_prio();
    t_level();
    t_power();
    t_pof();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    print_verdict();
  end
endmodule
